// ==== verilog/rbc_pkg.sv ====
// Constants for the reset and bus control block of a fixed-point processor.
// Assumes a single 50 MHz master clock shared by all users of the package.
package rbc_pkg;
   // ==========================================================
   // Widths
   localparam int RBC_DATA_W = 16;
   localparam int RBC_ADDR_W = 12;
   // ==========================================================
   // Reset values
   localparam logic [RBC_ADDR_W-1:0] RBC_PC_RESET = 12'h000;
   localparam logic [RBC_DATA_W-1:0] RBC_DATA_RESET = 16'h0000;
   // Cycle clock divider: cycle clock runs at master / 4
   localparam int RBC_DIV_W = 2;
   localparam logic [RBC_DIV_W-1:0] RBC_DIV_LAST = 2'h3;
   localparam logic [RBC_DIV_W-1:0] RBC_DIV_HALF = 2'h2;
   // Least reset pulse, in cycles of the cycle clock
   localparam logic [2:0] RBC_MIN_RESET_CYC = 3'h5;
   // Bus phase of the processor's own sequencer
   typedef enum logic [1:0] {
      RBC_ST_RESET = 2'b00,
      RBC_ST_WAIT = 2'b01,
      RBC_ST_RUN = 2'b11
   } rbc_state_t;
   // Bus operation request codes
   localparam logic [1:0] RBC_OP_NONE = 2'h0;
   localparam logic [1:0] RBC_OP_FETCH = 2'h1;
   localparam logic [1:0] RBC_OP_READ = 2'h2;
   localparam logic [1:0] RBC_OP_WRITE = 2'h3;
endpackage : rbc_pkg

// ==== verilog/rbc_sync.sv ====
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a pin; output is safe for logic on i_mclk.
`timescale 1ns/1ps
`default_nettype none
module rbc_sync (
   input wire logic i_mclk,
   input wire logic i_async,
   output logic o_sync
);
   logic meta;
   // ==========================================================
   // Synchroniser: first flop feeds only the second
   always_ff @(posedge i_mclk) begin
      meta <= i_async;
      o_sync <= meta;
   end
endmodule // rbc_sync
`default_nettype wire

// ==== verilog/rbc_reset_bus.sv ====
// Reset entry and exit for the strobed memory and peripheral bus.
// Assumes a 50 MHz master clock; the reset pin and requests are pin/core inputs.
// Notes on behaviour
// RULE1: Reset parks strobes high, floats data bus.
// RULE2: Address and counter clear after next cycle.
// RULE3: Source holds reset at least five cycles.
// RULE4: Execution resumes one cycle after release.
// RULE5: Never more than one strobe active.
// RULE6: Reset pin passes a clock synchroniser.
// RULE7: Write address during reset-cut write unreliable.
`timescale 1ns/1ps
`default_nettype none
module rbc_reset_bus
   import rbc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_reset_input_n,
   input wire logic [1:0] i_op,
   input wire logic [RBC_ADDR_W-1:0] i_op_addr,
   input wire logic [RBC_DATA_W-1:0] i_wr_data,
   input wire logic [RBC_DATA_W-1:0] i_data_in,
   output logic o_cycle_clock_out,
   output logic o_data_space_strobe_n,
   output logic o_write_strobe_n,
   output logic o_program_fetch_strobe_n,
   output logic [RBC_ADDR_W-1:0] o_address_outputs,
   output logic [RBC_ADDR_W-1:0] o_pc,
   output logic [RBC_DATA_W-1:0] o_data_out,
   output logic o_data_oe,
   output logic [RBC_DATA_W-1:0] o_rd_data,
   output logic o_running,
   output logic o_cycle_en
);
   // ==========================================================
   // Reset pin synchroniser
   logic rs_sync;
   rbc_sync u_rs_sync (
      .i_mclk(i_mclk),
      .i_async(i_reset_input_n),
      .o_sync(rs_sync)
   ); // RULE6

   // ==========================================================
   // Cycle clock divider, one enable per processor cycle
   logic [RBC_DIV_W-1:0] div;
   wire cyc_end = (div == RBC_DIV_LAST);
   assign o_cycle_en = cyc_end;
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         div <= '0;
         o_cycle_clock_out <= 1'b1;
      end else begin
         div <= div + 1'b1;
         o_cycle_clock_out <= (div + 1'b1) < RBC_DIV_HALF;
      end
   end

   // ==========================================================
   // Sequencer: reset held, one-cycle wait after release, then run
   rbc_state_t state;
   rbc_state_t next_state;
   wire rs_held = !rs_sync;
   always_comb begin
      next_state = state;
      case (state)
         RBC_ST_RESET: begin
            if (!rs_held && cyc_end) next_state = RBC_ST_WAIT;
         end
         RBC_ST_WAIT: begin
            if (rs_held) next_state = RBC_ST_RESET;
            else if (cyc_end) next_state = RBC_ST_RUN; // RULE4
         end
         RBC_ST_RUN: begin
            if (rs_held) next_state = RBC_ST_RESET;
         end
         default: next_state = RBC_ST_RESET;
      endcase
   end
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) state <= RBC_ST_RESET;
      else state <= next_state;
   end
   assign o_running = (state == RBC_ST_RUN);

   // ==========================================================
   // Clear of address and counter at the end of the next full cycle
   logic clr_armed;
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) clr_armed <= 1'b1;
      else if (!rs_held) clr_armed <= 1'b0;
      else if (cyc_end) clr_armed <= 1'b1; // RULE2
   end
   // A reset that lands mid-cycle waits out the rest of that cycle first
   wire do_clear = rs_held && cyc_end && clr_armed; // RULE2

   // ==========================================================
   // Bus operation decode; at most one strobe low by construction
   wire take_op = o_running && cyc_end;
   wire op_fetch = take_op && (i_op == RBC_OP_FETCH);
   wire op_read = take_op && (i_op == RBC_OP_READ);
   wire op_write = take_op && (i_op == RBC_OP_WRITE);
   logic [1:0] cur_op;
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n || rs_held) cur_op <= RBC_OP_NONE; // RULE1
      else if (cyc_end) cur_op <= o_running ? i_op : RBC_OP_NONE;
   end
   // Strobes are combinational so a reset pulls them high in the same cycle
   assign o_program_fetch_strobe_n = !((cur_op == RBC_OP_FETCH) && !rs_held); // RULE1 RULE5
   assign o_data_space_strobe_n = !((cur_op == RBC_OP_READ) && !rs_held); // RULE1 RULE5
   assign o_write_strobe_n = !((cur_op == RBC_OP_WRITE) && !rs_held); // RULE1 RULE5
   assign o_data_oe = (cur_op == RBC_OP_WRITE) && !rs_held; // RULE1

   // ==========================================================
   // Address outputs, program counter and data registers
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n || do_clear) begin
         o_pc <= RBC_PC_RESET; // RULE2
         o_address_outputs <= RBC_PC_RESET; // RULE2
      end else if (op_fetch) begin
         o_address_outputs <= o_pc;
         o_pc <= o_pc + 1'b1;
      end else if (op_read || op_write) begin
         // A write cut by reset may leave this address stale
         o_address_outputs <= i_op_addr; // RULE7
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_data_out <= RBC_DATA_RESET;
         o_rd_data <= RBC_DATA_RESET;
      end else begin
         if (op_write) o_data_out <= i_wr_data;
         if (cyc_end && cur_op != RBC_OP_NONE && !rs_held) o_rd_data <= i_data_in;
      end
   end

   // ==========================================================
   // Checks
   logic [2:0] low_cnt;
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n || !rs_held) low_cnt <= '0;
      else if (cyc_end && low_cnt != RBC_MIN_RESET_CYC) low_cnt <= low_cnt + 1'b1;
   end

   property p_strobes_parked;
      @(posedge i_mclk) disable iff (!i_reset_n)
      rs_held |-> (o_data_space_strobe_n && o_write_strobe_n
                   && o_program_fetch_strobe_n && !o_data_oe);
   endproperty
   a_strobes_parked: assert property (p_strobes_parked) // RULE1
      else $error("strobe or data active during reset");

   property p_one_strobe;
      @(posedge i_mclk) disable iff (!i_reset_n)
      $countones({!o_data_space_strobe_n, !o_write_strobe_n, !o_program_fetch_strobe_n}) <= 1;
   endproperty
   a_one_strobe: assert property (p_one_strobe) // RULE5
      else $error("two bus strobes active together");

   property p_clear_after_cycle;
      @(posedge i_mclk) disable iff (!i_reset_n)
      (low_cnt == 3'h2) |-> (o_pc == RBC_PC_RESET && o_address_outputs == RBC_PC_RESET);
   endproperty
   a_clear_after_cycle: assert property (p_clear_after_cycle) // RULE2
      else $error("address not cleared after reset cycle");

   property p_resume;
      @(posedge i_mclk) disable iff (!i_reset_n)
      $rose(rs_sync) ##1 (!rs_held) [*8] |-> o_running;
   endproperty
   a_resume: assert property (p_resume) // RULE4
      else $error("execution did not resume after release");

   property p_no_early_run;
      @(posedge i_mclk) disable iff (!i_reset_n)
      $rose(rs_sync) |=> !o_running [*4];
   endproperty
   a_no_early_run: assert property (p_no_early_run) // RULE4
      else $error("execution resumed before a full cycle");

   property p_sync_entry;
      @(posedge i_mclk) disable iff (!i_reset_n)
      $fell(i_reset_input_n) ##1 !i_reset_input_n ##1 !i_reset_input_n |=> !o_running;
   endproperty
   a_sync_entry: assert property (p_sync_entry) // RULE6
      else $error("reset entry latency wrong");

   property p_pc_hold;
      @(posedge i_mclk) disable iff (!i_reset_n)
      (!o_running && !do_clear) |=> $stable(o_pc);
   endproperty
   a_pc_hold: assert property (p_pc_hold) // RULE2
      else $error("program counter moved while halted");

   // Strobes and data bus parked two edges after the pin falls
   property p_parked_timely;
      @(posedge i_mclk) disable iff (!i_reset_n)
      $fell(i_reset_input_n) ##1 !i_reset_input_n |=> (o_data_space_strobe_n
                   && o_write_strobe_n && o_program_fetch_strobe_n && !o_data_oe);
   endproperty
   a_parked_timely: assert property (p_parked_timely) // RULE1
      else $error("bus not parked two edges after reset pin fell");

   // Release reaches the core exactly two edges after the pin rises
   property p_exit_latency;
      @(posedge i_mclk) disable iff (!i_reset_n)
      $rose(i_reset_input_n) |=> rs_held ##1 !rs_held;
   endproperty
   a_exit_latency: assert property (p_exit_latency) // RULE6
      else $error("reset release latency wrong");

   // While halted the address outputs move only for the clear
   property p_addr_hold;
      @(posedge i_mclk) disable iff (!i_reset_n)
      (!o_running && !do_clear) |=> $stable(o_address_outputs);
   endproperty
   a_addr_hold: assert property (p_addr_hold) // RULE2
      else $error("address outputs moved while halted");

   // Each fetch shows the counter on the address outputs and steps it by one
   property p_fetch_advances;
      @(posedge i_mclk) disable iff (!i_reset_n)
      (op_fetch && !do_clear) |=> (o_pc == $past(o_pc) + 1'b1)
                                  && (o_address_outputs == $past(o_pc));
   endproperty
   a_fetch_advances: assert property (p_fetch_advances) // RULE4
      else $error("fetch did not step the program counter");
endmodule // rbc_reset_bus
`default_nettype wire

// ==== verif/rbc_mem_model.sv ====
// External memory model for the strobed bus.
// Assumes active-low strobes and the block's address width.
`timescale 1ns/1ps
`default_nettype none
module rbc_mem_model
   import rbc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_strobe_n,
   input wire logic [RBC_ADDR_W-1:0] i_addr,
   output logic [RBC_DATA_W-1:0] o_data
);
   // ==========
   // Read data
   logic [RBC_DATA_W-1:0] junk = 16'h5a5a;
   // Released bus toggles so a stale word never passes as valid
   always @(posedge i_mclk) begin
      junk <= ~junk;
   end
   assign o_data = i_strobe_n ? junk : {4'ha, i_addr};
endmodule // rbc_mem_model
`default_nettype wire

// ==== verif/rbc_reset_bus_tb_top.sv ====
// Testbench for the reset and bus control block.
// Assumes the memory model answers on either read strobe.
`timescale 1ns/1ps
`default_nettype none
module rbc_reset_bus_tb_top;
   import rbc_pkg::*;
   // ==========
   // Harness
   logic i_mclk = 0, i_reset_n = 0, i_reset_input_n = 0;
   logic [1:0] i_op = 2'h0;
   logic [11:0] i_op_addr = 12'h000, ad;
   logic [15:0] i_wr_data = 16'h0000, mem_data, bus;
   logic ds_n, wr_n, pf_n, oe, run, cen, cko;
   logic [11:0] addr, pc;
   logic [15:0] dout, rdat;
   int mismatches = 0, checked = 0;
   always #10 i_mclk = ~i_mclk;
   // Wire level: block drives during writes, memory otherwise
   assign bus = oe ? dout : mem_data;
   rbc_reset_bus dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_reset_input_n(i_reset_input_n), .i_op(i_op), .i_op_addr(i_op_addr),
      .i_wr_data(i_wr_data), .i_data_in(bus), .o_cycle_clock_out(cko),
      .o_data_space_strobe_n(ds_n), .o_write_strobe_n(wr_n),
      .o_program_fetch_strobe_n(pf_n), .o_address_outputs(addr), .o_pc(pc),
      .o_data_out(dout), .o_data_oe(oe), .o_rd_data(rdat), .o_running(run),
      .o_cycle_en(cen));
   rbc_mem_model mem (.i_mclk(i_mclk), .i_strobe_n(ds_n & pf_n),
      .i_addr(addr), .o_data(mem_data));
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Issue one op, then look at the strobes one edge after it is taken
   task automatic issue(logic [1:0] op, logic [11:0] a, logic [2:0] st);
      int n;
      @(posedge i_mclk) i_op <= op;
      i_op_addr <= a;
      i_wr_data <= {4'h3, a};
      n = 0;
      do begin @(negedge i_mclk); n++; end while (cen !== 1'b1 && n < 20);
      // Cycle clock is low in the last two master clocks of a cycle
      chk("cko_low", 16'h0000, {15'h0, cko});
      @(posedge i_mclk) i_op <= 2'h0;
      @(negedge i_mclk);
      chk("cko_high", 16'h0001, {15'h0, cko});
      chk("strobes", {13'h0, st}, {13'h0, ds_n, wr_n, pf_n});
      chk("oe", {15'h0, op == 2'h3}, {15'h0, oe});
      // For a fetch the caller passes the counter value it expects
      chk("addr", {4'h0, a}, {4'h0, addr});
      if (op == 2'h3) chk("dout", {4'h3, a}, dout);
   endtask
   // Drop the pin and check parking, then hold it low past its least span and check the clear
   task automatic pin_reset();
      @(posedge i_mclk) i_reset_input_n <= 1'b0;
      repeat (3) @(negedge i_mclk);
      chk("park", 16'h0007, {13'h0, ds_n, wr_n, pf_n});
      chk("oe_off", 16'h0000, {15'h0, oe});
      repeat (20) @(negedge i_mclk);
      chk("addr_clr", 16'h0000, {4'h0, addr});
      chk("pc_clr", 16'h0000, {4'h0, pc});
      chk("halted", 16'h0000, {15'h0, run});
   endtask
   // Release the pin; run comes back only after the synchroniser
   task automatic release_pin();
      int n;
      @(posedge i_mclk) i_reset_input_n <= 1'b1;
      repeat (2) @(negedge i_mclk);
      chk("sync_hold", 16'h0000, {15'h0, run});
      n = 0;
      while (run !== 1'b1 && n < 14) begin @(negedge i_mclk); n++; end
      chk("resume", 16'h0001, {15'h0, run});
      chk("pc_start", 16'h0000, {4'h0, pc});
   endtask
   // Back-to-back read and write, a fetch, then a reset cutting a write
   task automatic bus_ops();
      ad = 12'h5c3;
      issue(2'h2, ad, 3'b011);
      issue(2'h3, 12'ha3c, 3'b101);
      chk("rd_data", {4'ha, ad}, rdat);
      issue(2'h1, 12'h000, 3'b110);
      chk("pc_inc", 16'h0001, {4'h0, pc});
      issue(2'h3, 12'h0ff, 3'b101);
      pin_reset();
      release_pin();
   endtask
   initial begin
      repeat (12) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      pin_reset();
      release_pin();
      bus_ops();
      wrap_up();
   end
   initial begin
      #20000;
      mismatches++;
      wrap_up();
   end
endmodule // rbc_reset_bus_tb_top
`default_nettype wire
